// ==== bench/mcs_sink.sv ====
// downstream consumer model of the sample stream
`timescale 1ns/1ps
module mcs_sink
	import mcs_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire mcs_sample_t sample_i,
	output logic      [15:0] count_o
);
	// no back-pressure exists, so every valid sample is taken
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			count_o <= 16'h0000;
		else if (sample_i.valid)
			count_o <= count_o + 16'h0001;
	end
endmodule

// ==== bench/mcs_synth_monitor.sv ====
// concurrent checks on the synthesiser ports
`timescale 1ns/1ps
module mcs_synth_monitor
	import mcs_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire mcs_sample_t sample_o
);
	logic [31:0] ctl;
	logic [7:0]  cnt;
	logic        first;
	logic [4:0]  lat;
	logic        start;
	// limitation: control writes while running are not modelled
	assign start = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000 && pwdata_i[0] && !ctl[0];
	assign lat = !ctl[7] ? 5'h04 : ctl[12:8] < 5'h02 ? 5'h02 : ctl[12:8] > 5'h11 ? 5'h11 : ctl[12:8];
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			ctl <= 32'h000F0500;
		else if (start)
			ctl <= pwdata_i;
		if (sys_rst_i || start)
			first <= 1'b1;
		else if (sample_o.valid)
			first <= 1'b0;
		cnt <= start ? 8'h00 : cnt == 8'hFF ? cnt : cnt + 8'h01;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sel_sine_a: assert property (sample_o.valid && ctl[6:5] == 2'h1 |-> sample_o.cosine == 16'h0000)
		else $error("cosine not zero");
	sel_cos_a: assert property (sample_o.valid && ctl[6:5] == 2'h2 |-> sample_o.sine == 16'h0000)
		else $error("sine not zero");
	full_span_a: assert property (sample_o.valid && ctl[4:3] == 2'h0 |-> sample_o.sine != 16'h8000
		&& sample_o.sine != 16'h8001 && sample_o.sine != 16'h7FFF) else $error("full range exceeded");
	half_span_a: assert property (sample_o.valid && ctl[4:3] == 2'h1 |-> $signed(sample_o.sine) <= 16'sh4000
		&& $signed(sample_o.sine) >= 16'shC000) else $error("half range exceeded");
	sign_mag_a: assert property (sample_o.valid && ctl[4] |-> sample_o.sine != 16'h8000
		&& sample_o.sine[14:0] <= 15'h7FFE) else $error("bad sign magnitude");
	chan_turn_a: assert property (sample_o.valid ##1 sample_o.valid |-> sample_o.chan ==
		($past(sample_o.chan) == ctl[19:16] ? 4'h0 : $past(sample_o.chan) + 4'h1)) else $error("channel order");
	first_lat_a: assert property (first && sample_o.valid |-> cnt == {3'h0, lat} + 8'h01)
		else $error("latency wrong");
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> !sample_o.valid)
		else $error("sample during reset");
	cover property (sample_o.valid && sample_o.sine == 16'h7FFE);
	cover property (sample_o.valid && sample_o.chan == 4'h3);
	cover property (first && sample_o.valid && ctl[7]);
endmodule
bind mcs_synth mcs_synth_monitor i_mon(.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .pready_o, .sample_o);

// ==== bench/multichannel_sine_cosine_synth_bench.sv ====
// self-checking bench: apb driver, wave model and random scenarios
`timescale 1ns/1ps
module multichannel_sine_cosine_synth_bench;
	import mcs_pkg::*;
	logic        clk, rst, psel, pen, pwr, rdy, err;
	logic [11:0] addr;
	logic [31:0] wdat, rdat;
	logic [15:0] seen;
	mcs_sample_t smp;
	int          failures = 0, total_checks = 0, cyc = 0, st[16], sh[16], acc[16];
	int unsigned seed = 63526;
	mcs_synth i_dut(.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err), .sample_o(smp));
	mcs_sink i_sink(.ref_clk_i(clk), .sys_rst_i(rst), .sample_i(smp), .count_o(seen));
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// quarter-point phases only, where the parabola is exact
	function automatic logic [15:0] wave(int q, bit half, bit sm, bit neg);
		int v;
		v = (q == 1) ? 1 : (q == 3) ? -1 : 0;
		v = v * (half ? 16384 : 32766) * (neg ? -1 : 1);
		if (sm && v < 0)
			return 16'h8000 | 16'(-v);
		return 16'(v);
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(bit w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1;
		do
			@(posedge clk);
		while (rdy !== 1'b1);
		r = rdat;
		e = err;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic scen(int i);
		logic [31:0] ctl, r;
		logic        e;
		int          last, lat, k, c, p, q;
		ctl = (rnd() & 32'h00031F86) | (32'(i % 3) << 5) | (32'(i[3:2]) << 3);
		last = ctl[17:16];
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		for (c = 0; c <= last; c++)
		begin
			st[c] = (rnd() % 4) * 32'h4000;
			sh[c] = (rnd() % 4) * 32'h4000;
			acc[c] = 0;
			apb(1, 12'h040 + 12'(4 * c), st[c], r, e);
			apb(1, 12'h080 + 12'(4 * c), sh[c], r, e);
		end
		apb(1, 12'h000, ctl | 32'h1, r, e);
		lat = !ctl[7] ? 4 : ctl[12:8] < 2 ? 2 : ctl[12:8] > 17 ? 17 : int'(ctl[12:8]);
		k = 0;
		while (smp.valid !== 1'b1 && k < 40)
		begin
			@(posedge clk);
			k++;
		end
		chk(16'(k), 16'(lat + 2));
		for (p = 0; p < 3 * (last + 1); p++)
		begin
			c = p % (last + 1);
			acc[c] = (acc[c] + st[c]) % 32'h10000;
			q = (acc[c] + sh[c]) % 32'h10000 / 32'h4000;
			chk(16'(smp.chan), 16'(c));
			chk(smp.sine, ctl[6:5] == 2 ? 16'h0 : wave(q, ctl[3], ctl[4], ctl[1]));
			chk(smp.cosine, ctl[6:5] == 1 ? 16'h0 : wave((q + 1) % 4, ctl[3], ctl[4], ctl[2]));
			@(posedge clk);
		end
		chk(seen, 16'(3 * (last + 1)));
		// status must still report the run bit while channels rotate
		apb(0, 12'h004, 0, r, e);
		chk(r[15:0] & 16'h0100, 16'h0100);
		$display("test ctl %h done", ctl);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			failures++;
			stop_test();
		end
	end
	initial
	begin
		logic [31:0] r;
		logic        e;
		rst = 1;
		psel = 0;
		pen = 0;
		pwr = 0;
		addr = 0;
		wdat = 0;
		repeat (10) @(posedge clk);
		rst <= 0;
		apb(0, 12'h000, 0, r, e);
		chk(r[15:0], 16'h0500);
		chk(r[31:16], 16'h000F);
		apb(0, 12'h044, 0, r, e);
		chk(r[15:0], 16'h0000);
		apb(0, 12'h084, 0, r, e);
		chk(r[15:0], 16'h0000);
		apb(0, 12'h004, 0, r, e);
		chk(r[15:0], 16'h0000);
		apb(0, 12'h100, 0, r, e);
		chk({r[14:0], e}, 16'h0001);
		$display("test registers done");
		for (int i = 0; i < 16; i++)
			scen(i);
		stop_test();
	end
endmodule

// ==== common/mcs_cfg.svh ====
// constants of the multichannel sine/cosine synthesiser
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH

`define MCS_PHASE_W      16
`define MCS_OUT_W        16
`define MCS_CHANNELS     16
`define MCS_CHAN_W       4
`define MCS_LAT_W        5
`define MCS_LAT_DEFAULT  5'h05
`define MCS_LAT_AUTO     5'h04
`define MCS_LAT_MIN      5'h02
`define MCS_TAP_MAX      5'h0F
`define MCS_QUARTER      16'h4000
`define MCS_HALF_PERIOD  16'h8000
`define MCS_FULL_PEAK    15'h7FFE
`define MCS_PROD_SHIFT   28
`define MCS_HALF_SHIFT   14

`define MCS_OFF_CTRL     12'h000
`define MCS_OFF_STATUS   12'h004
`define MCS_OFF_STEP     12'h040
`define MCS_OFF_SHIFT    12'h080
`define MCS_BANK_MASK    12'hFC0

`define MCS_CTRL_RUN     0
`define MCS_CTRL_NEG_SIN 1
`define MCS_CTRL_NEG_COS 2
`define MCS_CTRL_HALF    3
`define MCS_CTRL_SGNMAG  4
`define MCS_CTRL_SEL_LO  5
`define MCS_CTRL_MANUAL  7
`define MCS_CTRL_LAT_LO  8
`define MCS_CTRL_CHN_LO  16
`define MCS_STAT_RUN     8

`define MCS_SEL_BOTH     2'h0
`define MCS_SEL_SIN      2'h1
`define MCS_SEL_COS      2'h2

`endif

// ==== common/mcs_pkg.sv ====
// types shared by the synthesiser modules
`include "mcs_cfg.svh"

package mcs_pkg;

	typedef enum logic [1:0]
	{
		emit_both_waveforms = 2'h0,
		emit_sine_only      = 2'h1,
		emit_cosine_only    = 2'h2
	} mcs_select_t;

	typedef struct packed
	{
		logic                     valid;
		logic [`MCS_CHAN_W-1:0]   chan;
		logic [`MCS_OUT_W-1:0]    sine;
		logic [`MCS_OUT_W-1:0]    cosine;
	} mcs_sample_t;

	typedef struct packed
	{
		logic                     run;
		logic                     negate_sine;
		logic                     negate_cosine;
		logic                     scale_half_range;
		logic                     encode_sign_magnitude;
		mcs_select_t              select;
		logic                     manual_latency;
		logic [`MCS_LAT_W-1:0]    latency;
		logic [`MCS_CHAN_W-1:0]   chan_last;
	} mcs_ctrl_t;

endpackage

// ==== verilog/mcs_synth.sv ====
// multichannel phase accumulator with sine/cosine output and APB registers
//
// How it works
// - a negate option flips the sign of its waveform; otherwise plain waveform.
// - full range: peak is just under +1 and just over -1 at output width.
// - half range: samples span +0.5 to -0.5.
// - two's complement by default; sign plus magnitude when selected.
// - automatic latency picks its own depth; manual uses the set value clamped to 2..17, default 5.
// - every channel has its own phase step, unsigned, reset to zero.
// - every channel has its own phase shift added to accumulated phase, reset zero.
// - phase and output widths are sixteen bits, multiples of eight.
// - output sine only, cosine only, or both; both by default.
`timescale 1ns/1ps
`include "mcs_cfg.svh"

module mcs_synth
	import mcs_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output mcs_sample_t      sample_o
);

	localparam int NCH = `MCS_CHANNELS;
	localparam int DW  = `MCS_PHASE_W;

	typedef struct packed
	{
		mcs_ctrl_t                        ctrl;
		logic [NCH-1:0][DW-1:0]           acc;
		logic [NCH-1:0][DW-1:0]           per_channel_step;
		logic [NCH-1:0][DW-1:0]           per_channel_shift;
		logic [`MCS_CHAN_W-1:0]           cur;
		logic                             ph_valid;
		logic [`MCS_CHAN_W-1:0]           ph_chan;
		logic [DW-1:0]                    ph_phase;
		mcs_sample_t [NCH-1:0]            pipe;
		mcs_sample_t                      out;
		logic                             pready;
		logic                             pslverr;
		logic [31:0]                      prdata;
	} mcs_state_t;

	mcs_state_t st;
	mcs_state_t next_st;

	logic [`MCS_OUT_W-1:0] sine_w;
	logic [`MCS_OUT_W-1:0] cosine_w;
	logic [DW-1:0]         cos_phase;

	// bank decode shared by read and write paths
	function automatic logic [1:0] bank_of(input logic [11:0] addr);
		logic [1:0] b;
		b = 2'h3;
		if (addr == `MCS_OFF_CTRL)
			b = 2'h0;
		else if (addr == `MCS_OFF_STATUS)
			b = 2'h1;
		else if ((addr & `MCS_BANK_MASK) == `MCS_OFF_STEP && addr[1:0] == 2'h0)
			b = 2'h2;
		else if ((addr & `MCS_BANK_MASK) == `MCS_OFF_SHIFT && addr[1:0] == 2'h0)
			b = 2'h3;
		else
			b = 2'h1;
		return b;
	endfunction

	function automatic logic mapped(input logic [11:0] addr);
		logic m;
		m = (addr == `MCS_OFF_CTRL) || (addr == `MCS_OFF_STATUS)
			|| (((addr & `MCS_BANK_MASK) == `MCS_OFF_STEP) && addr[1:0] == 2'h0)
			|| (((addr & `MCS_BANK_MASK) == `MCS_OFF_SHIFT) && addr[1:0] == 2'h0);
		return m;
	endfunction

	function automatic logic [31:0] ctrl_word(input mcs_ctrl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`MCS_CTRL_RUN]                         = c.run;
		w[`MCS_CTRL_NEG_SIN]                     = c.negate_sine;
		w[`MCS_CTRL_NEG_COS]                     = c.negate_cosine;
		w[`MCS_CTRL_HALF]                        = c.scale_half_range;
		w[`MCS_CTRL_SGNMAG]                      = c.encode_sign_magnitude;
		w[`MCS_CTRL_SEL_LO+1:`MCS_CTRL_SEL_LO]   = c.select;
		w[`MCS_CTRL_MANUAL]                      = c.manual_latency;
		w[`MCS_CTRL_LAT_LO+4:`MCS_CTRL_LAT_LO]   = c.latency;
		w[`MCS_CTRL_CHN_LO+3:`MCS_CTRL_CHN_LO]   = c.chan_last;
		return w;
	endfunction

	// cosine is the sine a quarter period ahead
	assign cos_phase = st.ph_phase + `MCS_QUARTER;

	mcs_wave u_sine
	(
		.phase_i      (st.ph_phase),
		.half_range_i (st.ctrl.scale_half_range),
		.sign_mag_i   (st.ctrl.encode_sign_magnitude),
		.negate_i     (st.ctrl.negate_sine),
		.sample_o     (sine_w)
	);

	mcs_wave u_cosine
	(
		.phase_i      (cos_phase),
		.half_range_i (st.ctrl.scale_half_range),
		.sign_mag_i   (st.ctrl.encode_sign_magnitude),
		.negate_i     (st.ctrl.negate_cosine),
		.sample_o     (cosine_w)
	);

	always_comb
	begin
		logic [DW-1:0]          acc_new;
		logic [`MCS_LAT_W-1:0]  lat;
		logic [`MCS_LAT_W-1:0]  tap;
		logic [11:0]            addr;
		logic [`MCS_CHAN_W-1:0] idx;
		logic [1:0]             bank;
		mcs_sample_t            fresh;
		acc_new = '0;
		lat     = '0;
		tap     = '0;
		addr    = paddr_i;
		idx     = paddr_i[`MCS_CHAN_W+1:2];
		bank    = bank_of(paddr_i);
		fresh   = '0;
		next_st = st;

		// one wait state: pready rises the cycle after the access phase starts
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		if (psel_i && penable_i && !st.pready)
		begin
			next_st.pready  = 1'b1;
			next_st.pslverr = !mapped(addr);
			next_st.prdata  = 32'h0000_0000;
			if (!pwrite_i && mapped(addr))
			begin
				case (bank)
					2'h0:
						next_st.prdata = ctrl_word(st.ctrl);
					2'h1:
						next_st.prdata = {23'h00_0000, st.ctrl.run, 4'h0, st.cur};
					2'h2:
						next_st.prdata = {16'h0000, st.per_channel_step[idx]};
					2'h3:
						next_st.prdata = {16'h0000, st.per_channel_shift[idx]};
					default:
						next_st.prdata = 32'h0000_0000;
				endcase
			end
		end

		// channel rotation and accumulation
		next_st.ph_valid = 1'b0;
		if (st.ctrl.run)
		begin
			acc_new = st.acc[st.cur] + st.per_channel_step[st.cur];
			next_st.acc[st.cur] = acc_new;
			next_st.ph_valid = 1'b1;
			next_st.ph_chan  = st.cur;
			next_st.ph_phase = acc_new + st.per_channel_shift[st.cur];
			if (st.cur >= st.ctrl.chan_last)
				next_st.cur = '0;
			else
				next_st.cur = st.cur + 4'h1;
		end
		else if (st.cur > st.ctrl.chan_last)
			next_st.cur = '0;

		// write takes effect at the edge where pready is seen high
		if (psel_i && penable_i && st.pready && pwrite_i && mapped(addr))
		begin
			case (bank)
				2'h0:
				begin
					next_st.ctrl.run                   = pwdata_i[`MCS_CTRL_RUN];
					next_st.ctrl.negate_sine           = pwdata_i[`MCS_CTRL_NEG_SIN];
					next_st.ctrl.negate_cosine         = pwdata_i[`MCS_CTRL_NEG_COS];
					next_st.ctrl.scale_half_range      = pwdata_i[`MCS_CTRL_HALF];
					next_st.ctrl.encode_sign_magnitude = pwdata_i[`MCS_CTRL_SGNMAG];
					next_st.ctrl.select                = mcs_select_t'(pwdata_i[`MCS_CTRL_SEL_LO+1:`MCS_CTRL_SEL_LO]);
					next_st.ctrl.manual_latency        = pwdata_i[`MCS_CTRL_MANUAL];
					next_st.ctrl.latency               = pwdata_i[`MCS_CTRL_LAT_LO+4:`MCS_CTRL_LAT_LO];
					next_st.ctrl.chan_last             = pwdata_i[`MCS_CTRL_CHN_LO+3:`MCS_CTRL_CHN_LO];
				end
				2'h2:
					next_st.per_channel_step[idx] = pwdata_i[DW-1:0];
				2'h3:
					next_st.per_channel_shift[idx] = pwdata_i[DW-1:0];
				default:
					next_st.ctrl = st.ctrl;
			endcase
		end

		// lookup stage feeds the delay line
		fresh.valid  = st.ph_valid;
		fresh.chan   = st.ph_chan;
		fresh.sine   = '0;
		fresh.cosine = '0;
		if (st.ph_valid)
		begin
			case (st.ctrl.select)
				emit_sine_only:
					fresh.sine = sine_w;
				emit_cosine_only:
					fresh.cosine = cosine_w;
				default:
				begin
					fresh.sine   = sine_w;
					fresh.cosine = cosine_w;
				end
			endcase
		end
		next_st.pipe[0] = fresh;
		for (int k = 1; k < NCH; k++)
			next_st.pipe[k] = st.pipe[k-1];

		// latency counts edges from phase capture to sample_o
		if (st.ctrl.manual_latency)
			lat = st.ctrl.latency;
		else
			lat = `MCS_LAT_AUTO;
		if (lat < `MCS_LAT_MIN)
			lat = `MCS_LAT_MIN;
		tap = lat - `MCS_LAT_MIN;
		if (tap > `MCS_TAP_MAX)
			tap = `MCS_TAP_MAX;
		next_st.out = st.pipe[tap[`MCS_CHAN_W-1:0]];

		if (sys_rst_i)
		begin
			next_st = '0;
			next_st.ctrl.select  = emit_both_waveforms;
			next_st.ctrl.latency = `MCS_LAT_DEFAULT;
			next_st.ctrl.chan_last = 4'hF;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		st <= next_st;
	end

	assign prdata_o  = st.prdata;
	assign pready_o  = st.pready;
	assign pslverr_o = st.pslverr;
	assign sample_o  = st.out;

endmodule

// ==== verilog/mcs_wave.sv ====
// one waveform lookup: parabolic half-wave, scaling, negation and encoding
`timescale 1ns/1ps
`include "mcs_cfg.svh"

module mcs_wave
	import mcs_pkg::*;
(
	input  wire logic [`MCS_PHASE_W-1:0] phase_i,
	input  wire logic                    half_range_i,
	input  wire logic                    sign_mag_i,
	input  wire logic                    negate_i,
	output logic      [`MCS_OUT_W-1:0]   sample_o
);

	logic [`MCS_PHASE_W-2:0] pos;
	logic [`MCS_PHASE_W-1:0] rest;
	logic [31:0]             prod;
	logic [47:0]             scaled;
	logic [`MCS_OUT_W-1:0]   mag;
	logic                    sign;

	// 4x(1-x) stands in for sin(pi x); error stays under six percent of peak
	always_comb
	begin
		pos    = phase_i[`MCS_PHASE_W-2:0];
		rest   = `MCS_HALF_PERIOD - {1'b0, pos};
		prod   = {17'h0_0000, pos} * {16'h0000, rest};
		scaled = {16'h0000, prod} * {33'h0_0000_0000, `MCS_FULL_PEAK};
		if (half_range_i)
			mag = prod[`MCS_HALF_SHIFT+`MCS_OUT_W-1:`MCS_HALF_SHIFT];
		else
			mag = scaled[`MCS_PROD_SHIFT+`MCS_OUT_W-1:`MCS_PROD_SHIFT];
		sign = phase_i[`MCS_PHASE_W-1] ^ negate_i;
		if (mag == 16'h0000)
			sign = 1'b0;
		if (sign_mag_i)
			sample_o = {sign, mag[`MCS_OUT_W-2:0]};
		else if (sign)
			sample_o = 16'h0000 - mag;
		else
			sample_o = mag;
	end

endmodule
